// file: tb/spos_link_partner.sv
// behavioural far-side spi party: slave to a master design, master to a slave design
`timescale 1ns/1ps
`default_nettype none
module spos_link_partner (
    input wire logic cpol,
    input wire logic cpha,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic din,
    input wire logic [7:0] tx,
    output logic sclk_m,
    output logic sel_m_n,
    output logic dout,
    output logic [7:0] rx
);
    int edges = 0;
    logic [7:0] sh;
    initial
    begin
        sclk_m = 1'b0;
        sel_m_n = 1'b1;
        dout = 1'b0;
        rx = 8'h00;
    end
    always @(negedge sel_n)
    begin
        edges = 0;
        sh = tx;
        if (!cpha)
            dout = sh[7];
    end
    // no pull on the line, so a released line shows the inverse of its last level
    always @(posedge sel_n)
        dout = ~dout;
    // sample and change on alternate edges
    always @(sclk)
    begin
        if (!sel_n && edges < 16)
        begin
            edges = edges + 1;
            if (edges[0] != cpha)
                rx = {rx[6:0], din};
            else if (cpha && edges == 1)
                dout = sh[7];
            else
            begin
                sh = {sh[6:0], 1'b0};
                dout = sh[7];
            end
        end
    end
    // clock stands at its idle level outside frames
    task automatic run_master();
        sclk_m = cpol;
        // off the system clock edge, so the synchroniser sees no race
        #310 sel_m_n = 1'b0;
        #400;
        repeat (16)
        begin
            sclk_m = ~sclk_m;
            #100;
        end
        #300 sel_m_n = 1'b1;
    endtask : run_master
endmodule : spos_link_partner
`default_nettype wire

// file: tb/tb_spi_phase_order_status.sv
// self-checking bench for the spi phase, order and status block
`timescale 1ns/1ps
`default_nettype none
module tb_spi_phase_order_status;
    import spos_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cpol, cpha, foreign;
    logic [31:0] awaddr, wdata, araddr;
    logic [7:0] ptx;
    wire logic awready, wready, bvalid, arready, rvalid, irq, sclk_o, sclk_oe, ss_n_o;
    wire logic mosi_o, mosi_oe, miso_o, miso_oe, sclk_m, sel_m_n, pdout;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] prx;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'hcc2d152b;
    int mdl_cfg, mdl_mask;
    wire logic sclk_w = sclk_oe ? sclk_o : sclk_m;
    wire logic mosi_w = mosi_oe ? mosi_o : pdout;
    wire logic miso_w = miso_oe ? miso_o : pdout;
    wire logic ss_n_w = sel_m_n & ~foreign;

    spos_top #(.HALF_CYC(4)) u_spos_top (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .ss_n_i(ss_n_w), .ss_n_o(ss_n_o),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe)
    );
    spos_link_partner partner (
        .cpol(cpol), .cpha(cpha), .sclk(sclk_w), .sel_n(sclk_oe ? ss_n_o : sel_m_n),
        .din(sclk_oe ? mosi_w : miso_w), .tx(ptx), .sclk_m(sclk_m), .sel_m_n(sel_m_n),
        .dout(pdout), .rx(prx)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        bit ta = 0;
        bit tw = 0;
        awaddr <= {20'h0, a};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            if (awready && !ta)
            begin
                ta = 1;
                awvalid <= 1'b0;
            end
            if (wready && !tw)
            begin
                tw = 1;
                wvalid <= 1'b0;
            end
        end
        // bready stays up; lowering it here would clash with the next call's raise
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        araddr <= {20'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata[7:0];
        r = rresp;
    endtask : rd

    // a hang ends the run as a failure
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        logic [7:0] b, d, e;
        logic [1:0] r;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cpol, cpha, foreign} = '0;
        {awaddr, wdata, araddr, ptx} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CFG, d, r);
        check(d, 8'h01);
        rd(ADDR_STAT, d, r);
        check(d, 8'h00);
        rd(12'h004, d, r);
        check({6'h0, r}, {6'h0, RESP_SLVERR});
        wr(12'h010, 8'hFF, r);
        check({6'h0, r}, {6'h0, RESP_SLVERR});
        $display("test reset done");
        for (int k = 0; k < 8; k++)
        begin
            mdl_cfg = 'h11 + 8 * k[2] + 4 * k[1] + 2 * k[0];
            mdl_mask = k[0];
            b = 8'($random(seed));
            ptx <= 8'($random(seed));
            cpol <= k[2];
            cpha <= k[1];
            wr(ADDR_CFG, mdl_cfg[7:0], r);
            wr(ADDR_MASK, mdl_mask[7:0], r);
            rd(ADDR_CFG, d, r);
            check(d, mdl_cfg[7:0]);
            wr(ADDR_DATA, b, r);
            check({6'h0, r}, {6'h0, RESP_OKAY});
            rd(ADDR_STAT, d, r);
            check(d, 8'h80);
            repeat (60) if (d[7]) rd(ADDR_STAT, d, r);
            check(d, 8'h01);
            check({7'h0, irq}, {7'h0, mdl_mask[0]});
            check({7'h0, sclk_o}, {7'h0, k[2]});
            e = b;
            if (k[0])
                e = {<<{b}};
            check(prx, e);
            rd(ADDR_DATA, d, r);
            // far side sends msb first; low bit first in master reverses the received byte
            e = ptx;
            if (k[0])
                e = {<<{ptx}};
            check(d, e);
            wr(ADDR_STAT, 8'h01, r);
            rd(ADDR_STAT, d, r);
            check(d, 8'h00);
            check({7'h0, irq}, 8'h00);
            $display("test master %0d done", k);
        end
        cpol <= 1'b0;
        cpha <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_CFG, k[0] ? 8'h31 : 8'h11, r);
            wr(ADDR_MASK, 8'h40, r);
            wr(ADDR_DATA, b, r);
            foreign <= 1'b1;
            d = 8'h80;
            repeat (60) if (d[7]) rd(ADDR_STAT, d, r);
            foreign <= 1'b0;
            check(d, k[0] ? 8'h40 : 8'h01);
            check({7'h0, irq}, {7'h0, k[0]});
            wr(ADDR_STAT, 8'h01, r);
            rd(ADDR_STAT, d, r);
            check(d, 8'h00);
            $display("test fault %0d done", k);
        end
        for (int k = 0; k < 4; k++)
        begin
            cpol <= k[1];
            cpha <= k[0];
            b = 8'($random(seed));
            ptx <= 8'($random(seed));
            wr(ADDR_CFG, 8'(8'h01 + 8 * k[1] + 4 * k[0]), r);
            wr(ADDR_DATA, b, r);
            partner.run_master();
            // realign to a clock edge before the next bus request
            @(posedge aclk);
            check(prx, b);
            rd(ADDR_DATA, d, r);
            check(d, ptx);
            rd(ADDR_STAT, d, r);
            check(d, 8'h01);
            wr(ADDR_STAT, 8'h01, r);
            $display("test slave %0d done", k);
        end
        conclude();
    end
endmodule : tb_spi_phase_order_status
`default_nettype wire

// file: verilog/spos_pkg.sv
// constants, register map and state layout of the spi phase/order/status block
`default_nettype none
package spos_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_CFG = 8'hE9;
    localparam logic [7:0] IDX_STAT = 8'hEA;
    localparam logic [7:0] IDX_DATA = 8'hEB;
    localparam logic [7:0] IDX_MASK = 8'hEC;
    localparam logic [11:0] ADDR_CFG = {2'h0, IDX_CFG, 2'h0};
    localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
    localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
    localparam logic [11:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
    // config layout: [5] ss check, [4] master, [3] idle level, [2] phase, [1] low bit first, [0] irq mode
    localparam logic [5:0] CFG_RESET = 6'h01;
    localparam int STAT_BUSY_B = 7;
    localparam int STAT_MMF_B = 6;
    localparam int STAT_DONE_B = 0;
    localparam logic [4:0] EDGES = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_NS = 25;
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {PH_IDLE = 3'h1, PH_RUN = 3'h2, PH_TAIL = 3'h4} spos_phase_e;

    typedef struct packed {
        logic ss_check;
        logic master;
        logic idle_level;
        logic phase;
        logic low_bit_first;
        logic xfer_irq_mode;
    } spos_cfg_s;

    typedef struct packed {
        spos_cfg_s cfg;
        logic mmf;
        logic done;
        logic busy;
        logic [7:0] mask;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic [7:0] sh;
        logic [7:0] rsh;
        logic [4:0] cnt;
        logic [7:0] div;
        spos_phase_e ph;
        logic sclk_o;
        logic dout;
        logic ss_o;
        logic slv_drv;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [11:0] awaddr;
        logic [7:0] wdata;
        logic wstb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic irq;
        logic [2:0] sclk_s;
        logic [2:0] ss_s;
        logic [1:0] mosi_s;
        logic [1:0] miso_s;
    } spos_state_s;
endpackage : spos_pkg
`default_nettype wire

// file: verilog/spos_top.sv
// spi byte engine with phase, bit order (master mode only), busy and multimaster status over axi4-lite
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module spos_top
#(
    parameter int HALF_CYC = spos_pkg::SCLK_HALF_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic irq,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe
);
    import spos_pkg::*;

    if (HALF_CYC < 2 || HALF_CYC > 255)
    begin : g_bad_half
        $error("HALF_CYC must lie in 2..255");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    spos_state_s st;
    spos_state_s n;
    logic edge_ev;
    logic smp_ev;
    logic start_m;
    logic mm_hit;
    logic done_ev;
    logic lsbf;
    logic din;
    logic [4:0] k;
    logic [7:0] rd;

    function automatic logic first_bit(input logic [7:0] v, input logic lf);
        first_bit = lf ? v[0] : v[7];
    endfunction : first_bit

    function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lf);
        shift_out = lf ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
    endfunction : shift_out

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lf);
        shift_in = lf ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shift_in

    function automatic logic [7:0] stat_byte(input logic b, input logic m, input logic d);
        stat_byte = {b, m, 5'h00, d};
    endfunction : stat_byte

    always_comb
    begin
        n = st;
        edge_ev = 1'b0;
        smp_ev = 1'b0;
        start_m = 1'b0;
        mm_hit = 1'b0;
        done_ev = 1'b0;
        k = 5'h00;
        rd = 8'h00;
        n.sclk_s = {st.sclk_s[1:0], sclk_i};
        n.ss_s = {st.ss_s[1:0], ss_n_i};
        n.mosi_s = {st.mosi_s[0], mosi_i};
        n.miso_s = {st.miso_s[0], miso_i};
        lsbf = st.cfg.low_bit_first & st.cfg.master;
        din = st.cfg.master ? st.miso_s[1] : st.mosi_s[1];

        if (st.awready && awvalid)
        begin
            n.aw_have = 1'b1;
            n.awaddr = awaddr[11:0];
        end
        if (st.wready && wvalid)
        begin
            n.w_have = 1'b1;
            n.wdata = wdata[7:0];
            n.wstb = wstrb[0];
        end
        if (st.bvalid && bready)
            n.bvalid = 1'b0;
        if (st.aw_have && st.w_have && !st.bvalid)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (st.awaddr)
                ADDR_CFG:
                    if (st.wstb)
                        n.cfg = spos_cfg_s'(st.wdata[5:0]);
                ADDR_STAT:
                    if (st.wstb)
                    begin
                        // fault clears on a written zero, done on a written one
                        if (!st.wdata[STAT_MMF_B])
                            n.mmf = 1'b0;
                        if (st.wdata[STAT_DONE_B])
                            n.done = 1'b0;
                    end
                ADDR_DATA:
                    if (st.wstb)
                    begin
                        n.txd = st.wdata;
                        start_m = st.cfg.master && (st.ph == PH_IDLE);
                    end
                ADDR_MASK:
                    if (st.wstb)
                        n.mask = st.wdata;
                default:
                    n.bresp = RESP_SLVERR;
            endcase
        end

        if (st.rvalid && rready)
            n.rvalid = 1'b0;
        if (st.arready && arvalid)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            case (araddr[11:0])
                ADDR_CFG: rd = {2'h0, st.cfg};
                ADDR_STAT: rd = stat_byte(st.busy, st.mmf, st.done);
                ADDR_DATA: rd = st.rxd;
                ADDR_MASK: rd = st.mask;
                default:
                begin
                    rd = 8'h00;
                    n.rresp = RESP_SLVERR;
                end
            endcase
            n.rdata = rd;
        end

        case (st.ph)
            PH_IDLE:
            begin
                // clock rests at its idle level
                n.sclk_o = st.cfg.idle_level;
                n.cnt = 5'h00;
                n.div = 8'h00;
                if (start_m)
                begin
                    n.ph = PH_RUN;
                    n.busy = 1'b1;
                    n.ss_o = 1'b0;
                    n.sh = st.wdata;
                    n.dout = first_bit(st.wdata, lsbf);
                end
                else if (!st.cfg.master && !st.ss_s[1])
                begin
                    n.ph = PH_RUN;
                    n.busy = 1'b1;
                    n.slv_drv = 1'b1;
                    n.sh = st.txd;
                    n.dout = first_bit(st.txd, 1'b0);
                end
            end
            PH_RUN:
            begin
                if (st.cfg.master)
                begin
                    if (st.cfg.ss_check && !st.ss_s[1])
                    begin
                        mm_hit = 1'b1;
                        n.ph = PH_IDLE;
                        n.busy = 1'b0;
                        n.ss_o = 1'b1;
                    end
                    else if (st.div == HALF_LAST)
                    begin
                        n.div = 8'h00;
                        n.sclk_o = !st.sclk_o;
                        edge_ev = 1'b1;
                    end
                    else
                        n.div = st.div + 8'h01;
                end
                else if (st.ss_s[1])
                begin
                    // select released mid byte drops it
                    n.ph = PH_IDLE;
                    n.busy = 1'b0;
                    n.slv_drv = 1'b0;
                end
                else
                    edge_ev = st.sclk_s[2] != st.sclk_s[1];
                if (edge_ev)
                begin
                    k = st.cnt + 5'h01;
                    n.cnt = k;
                    // edge parity picks sample or change
                    smp_ev = k[0] ^ st.cfg.phase;
                    if (smp_ev)
                        n.rsh = shift_in(st.rsh, din, lsbf);
                    else if (!(st.cfg.phase && k == 5'h01))
                    begin
                        n.sh = shift_out(st.sh, lsbf);
                        n.dout = first_bit(n.sh, lsbf);
                    end
                    if (k == EDGES)
                    begin
                        n.ph = PH_TAIL;
                        n.rxd = n.rsh;
                        if (!st.cfg.master)
                        begin
                            n.busy = 1'b0;
                            done_ev = 1'b1;
                        end
                    end
                end
            end
            PH_TAIL:
            begin
                if (st.cfg.master)
                begin
                    // last half period lets the far end sample
                    if (st.div == HALF_LAST)
                    begin
                        n.ph = PH_IDLE;
                        n.busy = 1'b0;
                        n.ss_o = 1'b1;
                        done_ev = 1'b1;
                    end
                    else
                        n.div = st.div + 8'h01;
                end
                else if (st.ss_s[1])
                begin
                    n.ph = PH_IDLE;
                    n.slv_drv = 1'b0;
                end
            end
            default:
                n.ph = PH_IDLE;
        endcase

        // set wins over a same-cycle clear
        // fault set only by conflict
        if (mm_hit)
            n.mmf = 1'b1;
        if (done_ev)
            n.done = 1'b1;
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;
        n.arready = !n.rvalid;
        n.irq = |(stat_byte(1'b0, n.mmf, n.done) & n.mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.cfg <= spos_cfg_s'(CFG_RESET);
            st.ph <= PH_IDLE;
            st.ss_o <= 1'b1;
            st.ss_s <= 3'h7;
        end
        else
            st <= n;
    end

    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = {24'h000000, st.rdata};
    assign rresp = st.rresp;
    assign irq = st.irq;
    assign sclk_o = st.sclk_o;
    assign sclk_oe = st.cfg.master;
    assign ss_n_o = st.ss_o;
    assign mosi_o = st.dout;
    assign mosi_oe = st.cfg.master;
    assign miso_o = st.dout;
    assign miso_oe = st.slv_drv;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_mstart;
        start_m;
    endsequence
    sequence s_mm_cond;
        st.ph == PH_RUN && st.cfg.master && st.cfg.ss_check && !st.ss_s[1];
    endsequence

    chk_busy_idle: assert property (st.ph == PH_IDLE |-> !st.busy)
        else $error("busy set while idle");
    chk_busy_run: assert property (st.ph == PH_RUN |-> st.busy)
        else $error("busy low during a byte");
    chk_mmf_set: assert property (s_mm_cond |=> st.mmf && st.ph == PH_IDLE && st.ss_o)
        else $error("fault not raised on foreign select");
    chk_mmf_cause: assert property ($rose(st.mmf) |-> $past(mm_hit))
        else $error("fault rose without conflict");
    chk_msb_first: assert property (start_m && !lsbf |=> st.dout == $past(st.wdata[7]) ##1 st.busy)
        else $error("msb not first");
    chk_lsb_first: assert property (start_m && lsbf |=> st.dout == $past(st.wdata[0]))
        else $error("lsb not first");
    chk_sample_hold: assert property (edge_ev && smp_ev |=> $stable(st.dout))
        else $error("output moved on a sample edge");
    chk_phase1_first: assert property (edge_ev && st.cfg.phase && st.cnt == 5'h00 |=> $stable(st.dout))
        else $error("first phase-one edge shifted twice");
    chk_sclk_idle: assert property (st.ph == PH_IDLE ##1 st.ph == PH_IDLE |-> st.sclk_o == $past(st.cfg.idle_level))
        else $error("clock not at idle level");
    chk_irq_level: assert property (st.irq == |(stat_byte(1'b0, st.mmf, st.done) & st.mask))
        else $error("irq does not follow status and mask");
    chk_start_seq: assert property (s_mstart |=> st.busy && !st.ss_o && st.ph == PH_RUN)
        else $error("master start did not begin a byte");
endmodule : spos_top
`default_nettype wire
